// [src/crate_controller_register_front.sv]
// Register front end of a crate controller: target decode, action register, register file
// Summary of operation
// - Targets decoded by address: action block 1, stacks 2 and 3, generator 4, buffer 5.
// - Primary sequence is started on every event trigger during acquisition.
// - Auxiliary sequence also runs periodically, by event count or elapsed time.
// - Action block holds only the action register at address 0x01.
// - Action bit 0 set enters acquisition; cleared leaves it.
// - Primary start comes from logic input one or masked service request lines.
// - Writing one to action bit 1 makes a 150 ns host trigger pulse.
// - Host trigger can feed either gate generator and green indicator; logic outputs see it only through a generator.
// - Writing one to action bit 2 clears internal sequencing registers.
// - Action bit 4 starts auxiliary sequence only when acquiring and loaded.
// - Action bits 1 to 3 clear themselves 150 ns after a write of one.
// - Register file holds firmware identifier plus eleven parameter words.
// - Three read-only words return counter values and service request lines.
// - Station 25 function 0 reads, function 16 writes; subaddress picks register.
// - All reads return 32 bits; mode and delays writes keep 16 bits.
// - Subaddress 0xF returns the 32-bit broadcast notepad on read.
// - Identifier packs month, year, beta, major and minor revision fields.
`timescale 1ns/10ps
module crate_controller_register_front
    import crate_front_pkg::*;
#(
    // Identifier field values are arbitrary
    parameter logic [2:0] FW_MONTH = 3'h1,
    parameter logic [4:0] FW_YEAR = 5'h01,
    parameter logic [7:0] FW_BETA = 8'h00,
    parameter logic [7:0] FW_MAJOR = 8'h01,
    parameter logic [7:0] FW_MINOR = 8'h00,
    parameter int HALF_SEC_TICKS = HALF_SEC_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic [2:0] req_target,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic [4:0] req_station,
    input wire logic [4:0] req_function,
    input wire logic [3:0] req_subaddr,
    input wire logic [31:0] req_wdata,
    input wire logic logic_input_one,
    input wire logic [23:0] service_request_in,
    input wire logic [31:0] counter_one_in,
    input wire logic [31:0] counter_two_in,
    input wire logic [31:0] broadcast_map_in,
    input wire logic aux_loaded,
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic primary_stack_strobe,
    output logic auxiliary_stack_strobe,
    output logic dataway_cmd_strobe,
    output logic out_buffer_strobe,
    output logic acquire,
    output logic primary_start,
    output logic aux_start,
    output logic host_trigger,
    output logic clear_pulse,
    output logic spare_pulse,
    output logic [1:0] gate_out,
    output logic [2:0] logic_outputs,
    output logic green_indicator
);
    localparam logic [31:0] FW_WORD = {FW_MONTH, FW_YEAR, FW_BETA, FW_MAJOR, FW_MINOR};
    localparam logic [4:0] PULSE_LOAD = 5'(PULSE_CYCLES);

    function automatic logic [31:0] write_mask(input logic [3:0] sa);
        case (sa)
            SA_GLOBAL_MODE, SA_DELAYS: write_mask = MASK_16;
            SA_PERIODIC, SA_SREQ_MASK: write_mask = MASK_24;
            SA_INDICATOR_SEL, SA_OUTPUT_SEL, SA_DEVICE_SEL, SA_GEN_ONE, SA_GEN_TWO,
            SA_EXT_DELAYS, SA_HOST_BUF: write_mask = MASK_32;
            default: write_mask = MASK_NONE;
        endcase
    endfunction : write_mask

    function automatic logic [1:0] sel_code(input logic [31:0] w, input int slot);
        sel_code = w[slot * SEL_STRIDE +: 2];
    endfunction : sel_code

    logic action_hit;
    logic action_wr;
    logic self_cmd;
    logic self_rd;
    logic self_wr;
    logic [31:0] cfg_reg [0:15];
    logic [31:0] rd_word;
    logic run_reg;
    logic [2:0] pulse_reg;
    logic [4:0] pulse_cnt [1:3];
    logic [2:0] pulse_load;
    logic input_one_d;
    logic sreq_match_d;
    logic sreq_match;
    logic event_trig;
    logic aux_soft;
    logic aux_by_count;
    logic aux_by_time;
    logic [15:0] evt_cnt;
    logic [31:0] tick_cnt;
    logic [7:0] half_cnt;
    logic tick_wrap;
    logic [15:0] evt_num;
    logic [7:0] time_num;
    logic [1:0] gen_q;

    assign action_hit = req_valid && req_target == TGT_ACTION_BLOCK && req_addr == ACTION_ADDR;
    assign action_wr = action_hit && req_write;
    assign self_cmd = req_valid && req_target == TGT_CMD_GEN && req_station == SELF_STATION;
    assign self_rd = self_cmd && req_function == FN_READ;
    assign self_wr = self_cmd && req_function == FN_WRITE;
    assign evt_num = cfg_reg[SA_PERIODIC][EVT_NUM_LSB +: 16];
    assign time_num = cfg_reg[SA_PERIODIC][TIME_LSB +: 8];

    // Parameter words; read-only locations get an empty mask and are never stored
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                cfg_reg[i] <= CFG_RESET;
            end
        end else if (self_wr) begin
            cfg_reg[req_subaddr] <= req_wdata & write_mask(req_subaddr);
        end
    end

    always_comb begin
        case (req_subaddr)
            SA_FW_ID: rd_word = FW_WORD;
            SA_SREQ_LINES: rd_word = {8'h00, service_request_in};
            SA_COUNTER_ONE: rd_word = counter_one_in;
            SA_COUNTER_TWO: rd_word = counter_two_in;
            SA_NOTEPAD: rd_word = broadcast_map_in;
            default: rd_word = cfg_reg[req_subaddr];
        endcase
    end

    // Answers: action register or register-file word, zero for other action block addresses
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp_data <= 32'h00000000;
        end else begin
            resp_valid <= req_valid && !req_write && (req_target == TGT_ACTION_BLOCK || self_rd);
            if (req_valid && !req_write && req_target == TGT_ACTION_BLOCK) begin
                resp_data <= action_hit ? {16'h0000, 11'h000, 1'b0, pulse_reg, run_reg} : 32'h00000000;
            end else if (self_rd) begin
                resp_data <= rd_word;
            end
        end
    end

    // Forwarded targets
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            primary_stack_strobe <= 1'b0;
            auxiliary_stack_strobe <= 1'b0;
            dataway_cmd_strobe <= 1'b0;
            out_buffer_strobe <= 1'b0;
        end else begin
            primary_stack_strobe <= req_valid && req_target == TGT_PRIMARY;
            auxiliary_stack_strobe <= req_valid && req_target == TGT_AUXILIARY;
            dataway_cmd_strobe <= req_valid && req_target == TGT_CMD_GEN && !self_cmd;
            out_buffer_strobe <= req_valid && req_target == TGT_OUT_BUF;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_reg <= 1'b0;
            acquire <= 1'b0;
        end else begin
            if (action_wr) begin
                run_reg <= req_wdata[ACT_RUN_BIT];
                acquire <= req_wdata[ACT_RUN_BIT];
            end
        end
    end

    // Self-clearing pulse bits; a new write of one restarts the full width
    genvar p;
    generate
        for (p = 1; p <= 3; p++) begin : g_pulse
            assign pulse_load[p-1] = action_wr && req_wdata[p];
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pulse_cnt[p] <= 5'h00;
                    pulse_reg[p-1] <= 1'b0;
                end else if (pulse_load[p-1]) begin
                    pulse_cnt[p] <= PULSE_LOAD;
                    pulse_reg[p-1] <= 1'b1;
                end else if (pulse_cnt[p] != 5'h00) begin
                    pulse_cnt[p] <= pulse_cnt[p] - 5'h01;
                    pulse_reg[p-1] <= pulse_cnt[p] > 5'h01;
                end
            end
        end
    endgenerate
    assign host_trigger = pulse_reg[ACT_HOST_TRIG_BIT-1];
    assign clear_pulse = pulse_reg[ACT_CLEAR_BIT-1];
    assign spare_pulse = pulse_reg[ACT_SPARE_BIT-1];

    assign sreq_match = |(service_request_in & cfg_reg[SA_SREQ_MASK][23:0]);
    assign event_trig = run_reg && ((logic_input_one && !input_one_d) || (sreq_match && !sreq_match_d));
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            input_one_d <= 1'b0;
            sreq_match_d <= 1'b0;
            primary_start <= 1'b0;
        end else begin
            input_one_d <= logic_input_one;
            sreq_match_d <= sreq_match;
            primary_start <= event_trig;
        end
    end

    // Auxiliary starts: software, event count or timer, whichever comes first
    assign aux_soft = action_wr && req_wdata[ACT_AUX_BIT] && run_reg && aux_loaded;
    assign tick_wrap = tick_cnt == 32'(HALF_SEC_TICKS - 1);
    assign aux_by_count = evt_num != 16'h0000 && event_trig && evt_cnt + 16'h0001 >= evt_num;
    assign aux_by_time = time_num != 8'h00 && tick_wrap && half_cnt + 8'h01 >= time_num;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aux_start <= 1'b0;
            evt_cnt <= 16'h0000;
            tick_cnt <= 32'h00000000;
            half_cnt <= 8'h00;
        end else begin
            aux_start <= aux_soft || (run_reg && aux_loaded && (aux_by_count || aux_by_time));
            if (!run_reg || pulse_load[ACT_CLEAR_BIT-1] || aux_start) begin
                evt_cnt <= 16'h0000;
                tick_cnt <= 32'h00000000;
                half_cnt <= 8'h00;
            end else begin
                if (event_trig) begin
                    evt_cnt <= evt_cnt + 16'h0001;
                end
                tick_cnt <= tick_wrap ? 32'h00000000 : tick_cnt + 32'h00000001;
                if (tick_wrap) begin
                    half_cnt <= half_cnt + 8'h01;
                end
            end
        end
    end

    // Two delay-and-gate generators
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_gen
            gen_state_e state;
            logic [15:0] cnt;
            logic trig;
            logic [31:0] timing;
            assign timing = cfg_reg[SA_GEN_ONE + 4'(g)];
            always_comb begin
                case (sel_code(cfg_reg[SA_DEVICE_SEL], g))
                    TRIG_INPUT_ONE: trig = logic_input_one && !input_one_d;
                    TRIG_HOST: trig = pulse_load[ACT_HOST_TRIG_BIT-1];
                    TRIG_EVENT: trig = event_trig;
                    default: trig = 1'b0;
                endcase
            end
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    state <= GEN_IDLE;
                    cnt <= 16'h0000;
                    gen_q[g] <= 1'b0;
                end else if (pulse_load[ACT_CLEAR_BIT-1]) begin
                    state <= GEN_IDLE;
                    cnt <= 16'h0000;
                    gen_q[g] <= 1'b0;
                end else begin
                    case (state)
                        GEN_IDLE: begin
                            if (trig) begin
                                state <= GEN_DELAY;
                                cnt <= timing[GEN_DELAY_LSB +: 16];
                            end
                        end
                        GEN_DELAY: begin
                            if (cnt == 16'h0000) begin
                                state <= GEN_GATE;
                                cnt <= timing[GEN_WIDTH_LSB +: 16];
                                gen_q[g] <= 1'b1;
                            end else begin
                                cnt <= cnt - 16'h0001;
                            end
                        end
                        GEN_GATE: begin
                            if (cnt == 16'h0000) begin
                                state <= GEN_IDLE;
                                gen_q[g] <= 1'b0;
                            end else begin
                                cnt <= cnt - 16'h0001;
                            end
                        end
                        default: begin
                            state <= GEN_IDLE;
                            gen_q[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate
    assign gate_out = gen_q;

    // Logic outputs and green indicator
    genvar o;
    generate
        for (o = 0; o < 3; o++) begin : g_out
            logic src;
            always_comb begin
                case (sel_code(cfg_reg[SA_OUTPUT_SEL], o))
                    SRC_ACQUIRE: src = run_reg;
                    SRC_EVENT: src = event_trig;
                    SRC_GEN_ONE: src = gen_q[0];
                    SRC_GEN_TWO: src = gen_q[1];
                    default: src = 1'b0;
                endcase
            end
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    logic_outputs[o] <= 1'b0;
                end else begin
                    logic_outputs[o] <= src ^ cfg_reg[SA_OUTPUT_SEL][o * SEL_STRIDE + SEL_INVERT_OFS];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            green_indicator <= 1'b0;
        end else begin
            case (cfg_reg[SA_INDICATOR_SEL][GREEN_POS +: 3])
                GREEN_ACQUIRE: green_indicator <= run_reg;
                GREEN_INPUT_ONE: green_indicator <= logic_input_one;
                GREEN_HOST_TRIG: green_indicator <= pulse_reg[ACT_HOST_TRIG_BIT-1];
                default: green_indicator <= 1'b0;
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_run_bit;
        action_wr |=> acquire == $past(req_wdata[ACT_RUN_BIT]);
    endproperty
    a_run_bit: assert property (p_run_bit) else $error("acquire does not follow bit 0");
    property p_host_width;
        $rose(host_trigger) |-> host_trigger [*8];
    endproperty
    a_host_width: assert property (p_host_width) else $error("host trigger too short");
    property p_pulse_end;
        pulse_cnt[2] == 5'h01 && !pulse_load[1] |=> !clear_pulse;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("clear pulse not self clearing");
    property p_decode;
        req_valid && req_target == TGT_PRIMARY |=> primary_stack_strobe && !out_buffer_strobe;
    endproperty
    a_decode: assert property (p_decode) else $error("primary target not decoded");
    property p_aux_gate;
        aux_start |-> $past(run_reg && aux_loaded);
    endproperty
    a_aux_gate: assert property (p_aux_gate) else $error("aux start outside acquisition");
    property p_primary_gate;
        primary_start |-> $past(acquire);
    endproperty
    a_primary_gate: assert property (p_primary_gate) else $error("primary start outside acquisition");
    property p_fw_read;
        self_rd && req_subaddr == SA_FW_ID |=> resp_valid && resp_data == FW_WORD;
    endproperty
    a_fw_read: assert property (p_fw_read) else $error("identifier read wrong");
    property p_mode_16;
        cfg_reg[SA_GLOBAL_MODE][31:16] == 16'h0000 && cfg_reg[SA_DELAYS][31:16] == 16'h0000;
    endproperty
    a_mode_16: assert property (p_mode_16) else $error("upper bits stored");
    property p_ro_ignored;
        req_valid && req_write && req_target == TGT_ACTION_BLOCK && !action_hit |=> $stable(acquire);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("unmapped write had effect");
    property p_clear_event;
        pulse_load[ACT_CLEAR_BIT-1] |=> clear_pulse && evt_cnt == 16'h0000;
    endproperty
    a_clear_event: assert property (p_clear_event) else $error("clear had no effect");

    c_soft_aux: cover property (aux_soft ##1 aux_start);
    c_event_start: cover property (acquire ##1 primary_start);
    c_gate_pulse: cover property (host_trigger ##[1:40] gate_out[0]);
    c_notepad: cover property (self_rd && req_subaddr == SA_NOTEPAD ##1 resp_valid);
endmodule : crate_controller_register_front

// [src/crate_front_pkg.sv]
// Constants, address map and types shared by the crate controller register front
package crate_front_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS = 150;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_SEC_NS = 500000000;
    localparam int HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;

    localparam logic [2:0] TGT_ACTION_BLOCK = 3'h1;
    localparam logic [2:0] TGT_PRIMARY = 3'h2;
    localparam logic [2:0] TGT_AUXILIARY = 3'h3;
    localparam logic [2:0] TGT_CMD_GEN = 3'h4;
    localparam logic [2:0] TGT_OUT_BUF = 3'h5;
    localparam logic [7:0] ACTION_ADDR = 8'h01;

    localparam int ACT_RUN_BIT = 0;
    localparam int ACT_HOST_TRIG_BIT = 1;
    localparam int ACT_CLEAR_BIT = 2;
    localparam int ACT_SPARE_BIT = 3;
    localparam int ACT_AUX_BIT = 4;
    localparam logic [15:0] ACTION_RESET = 16'h0000;

    localparam logic [4:0] SELF_STATION = 5'h19;
    localparam logic [4:0] FN_READ = 5'h00;
    localparam logic [4:0] FN_WRITE = 5'h10;

    localparam logic [3:0] SA_FW_ID = 4'h0;
    localparam logic [3:0] SA_GLOBAL_MODE = 4'h1;
    localparam logic [3:0] SA_DELAYS = 4'h2;
    localparam logic [3:0] SA_PERIODIC = 4'h3;
    localparam logic [3:0] SA_INDICATOR_SEL = 4'h4;
    localparam logic [3:0] SA_OUTPUT_SEL = 4'h5;
    localparam logic [3:0] SA_DEVICE_SEL = 4'h6;
    localparam logic [3:0] SA_GEN_ONE = 4'h7;
    localparam logic [3:0] SA_GEN_TWO = 4'h8;
    localparam logic [3:0] SA_SREQ_MASK = 4'h9;
    localparam logic [3:0] SA_SREQ_LINES = 4'ha;
    localparam logic [3:0] SA_COUNTER_ONE = 4'hb;
    localparam logic [3:0] SA_COUNTER_TWO = 4'hc;
    localparam logic [3:0] SA_EXT_DELAYS = 4'hd;
    localparam logic [3:0] SA_HOST_BUF = 4'he;
    localparam logic [3:0] SA_NOTEPAD = 4'hf;

    localparam logic [31:0] MASK_16 = 32'h0000ffff;
    localparam logic [31:0] MASK_24 = 32'h00ffffff;
    localparam logic [31:0] MASK_32 = 32'hffffffff;
    localparam logic [31:0] MASK_NONE = 32'h00000000;
    localparam logic [31:0] CFG_RESET = 32'h00000000;

    localparam int FW_MONTH_POS = 29;
    localparam int FW_YEAR_POS = 24;
    localparam int FW_BETA_POS = 16;
    localparam int FW_MAJOR_POS = 8;
    localparam int FW_MINOR_POS = 0;

    localparam int EVT_NUM_LSB = 0;
    localparam int TIME_LSB = 16;
    localparam int SEL_STRIDE = 8;
    localparam int SEL_INVERT_OFS = 4;
    localparam int GEN_DELAY_LSB = 0;
    localparam int GEN_WIDTH_LSB = 16;

    localparam logic [1:0] SRC_ACQUIRE = 2'h0;
    localparam logic [1:0] SRC_EVENT = 2'h1;
    localparam logic [1:0] SRC_GEN_ONE = 2'h2;
    localparam logic [1:0] SRC_GEN_TWO = 2'h3;
    localparam logic [1:0] TRIG_INPUT_ONE = 2'h0;
    localparam logic [1:0] TRIG_HOST = 2'h1;
    localparam logic [1:0] TRIG_EVENT = 2'h2;
    localparam int GREEN_POS = 8;
    localparam logic [2:0] GREEN_ACQUIRE = 3'h0;
    localparam logic [2:0] GREEN_INPUT_ONE = 3'h1;
    localparam logic [2:0] GREEN_HOST_TRIG = 3'h3;

    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_DELAY = 3'b010,
        GEN_GATE = 3'b100
    } gen_state_e;
endpackage : crate_front_pkg

// [tb/usb_host_model.sv]
// Host side model that issues register requests to the controller front end
`timescale 1ns/10ps
module usb_host_model
    import crate_front_pkg::*;
(
    input wire logic core_clk,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data,
    output logic req_valid,
    output logic [2:0] req_target,
    output logic req_write,
    output logic [7:0] req_addr,
    output logic [4:0] req_station,
    output logic [4:0] req_function,
    output logic [3:0] req_subaddr,
    output logic [31:0] req_wdata
);
    initial begin
        {req_valid, req_target, req_write, req_addr, req_station, req_function, req_subaddr, req_wdata} = '0;
    end

    // One request, then up to three cycles for an answer; q stays unknown if none comes
    task automatic xfer(input logic [2:0] t, input logic w, input logic [7:0] a, input logic [4:0] n,
                        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        {req_valid, req_target, req_write, req_addr, req_station, req_subaddr, req_wdata} <= {1'b1, t, w, a, n, s, d};
        req_function <= w ? FN_WRITE : FN_READ;
        @(posedge core_clk);
        req_valid <= 1'b0;
        // Released data line no longer shows the written word
        req_wdata <= ~d;
        q = 32'hxxxxxxxx;
        for (int i = 0; i < 3; i++) begin
            #1;
            if (resp_valid === 1'b1) q = resp_data;
            @(posedge core_clk);
        end
    endtask : xfer
endmodule : usb_host_model

// [tb/crate_controller_register_front_tb.sv]
// Self-checking bench for the crate controller register front
`timescale 1ns/10ps
module crate_controller_register_front_tb;
    import crate_front_pkg::*;
    typedef struct {logic [3:0] s; logic [31:0] d; logic [31:0] e;} row_s;
    logic core_clk, rstn, logic_input_one, aux_loaded, req_valid, req_write, resp_valid;
    logic [2:0] req_target;
    logic [7:0] req_addr;
    logic [4:0] req_station, req_function;
    logic [3:0] req_subaddr;
    logic [31:0] req_wdata, resp_data, q;
    logic [23:0] service_request_in;
    logic primary_stack_strobe, auxiliary_stack_strobe, dataway_cmd_strobe, out_buffer_strobe;
    logic primary_start, aux_start, acquire, host_trigger, clear_pulse, spare_pulse;
    logic [1:0] gate_out;
    logic [2:0] logic_outputs;
    logic green_indicator;
    logic [11:0] sv;
    int ev[12] = '{default: 0};
    int base[12];
    int bad_count = 0;
    int check_count = 0;
    row_s rows[10] = '{'{SA_FW_ID, 32'hffffffff, 32'hba3c967e}, '{SA_GLOBAL_MODE, 32'hffffffff, 32'h0000ffff},
        '{SA_DELAYS, 32'h12345678, 32'h00005678}, '{SA_PERIODIC, 32'hff000000, 32'h00000000},
        '{SA_INDICATOR_SEL, 32'h12345678, 32'h12345678}, '{SA_SREQ_MASK, 32'hff000001, 32'h00000001},
        '{SA_SREQ_LINES, 32'hffffffff, 32'h00800000}, '{SA_COUNTER_ONE, 32'h0, 32'h0a0b0c0d},
        '{SA_COUNTER_TWO, 32'h0, 32'h11223344}, '{SA_NOTEPAD, 32'hffffffff, 32'h55aa55aa}};

    crate_controller_register_front #(.HALF_SEC_TICKS(10), .FW_MONTH(3'h5), .FW_YEAR(5'h1a), .FW_BETA(8'h3c),
        .FW_MAJOR(8'h96), .FW_MINOR(8'h7e)) crate_controller_register_front_inst (
        .core_clk, .rstn, .req_valid, .req_target, .req_write, .req_addr, .req_station, .req_function,
        .req_subaddr, .req_wdata, .logic_input_one, .service_request_in, .counter_one_in(32'h0a0b0c0d),
        .counter_two_in(32'h11223344), .broadcast_map_in(32'h55aa55aa), .aux_loaded, .resp_valid, .resp_data,
        .primary_stack_strobe, .auxiliary_stack_strobe, .dataway_cmd_strobe, .out_buffer_strobe, .acquire,
        .primary_start, .aux_start, .host_trigger, .clear_pulse, .spare_pulse, .gate_out, .logic_outputs,
        .green_indicator);
    usb_host_model usb_host_model_inst (.core_clk, .resp_valid, .resp_data, .req_valid, .req_target,
        .req_write, .req_addr, .req_station, .req_function, .req_subaddr, .req_wdata);

    assign sv = {green_indicator, logic_outputs[0], gate_out[0], spare_pulse, clear_pulse, host_trigger, aux_start,
                 primary_start, out_buffer_strobe, dataway_cmd_strobe, auxiliary_stack_strobe, primary_stack_strobe};
    always @(posedge core_clk) begin
        for (int k = 0; k < 12; k++) ev[k] <= ev[k] + int'(sv[k] === 1'b1);
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic act_w(input logic [31:0] d);
        usb_host_model_inst.xfer(TGT_ACTION_BLOCK, 1'b1, ACTION_ADDR, 5'h00, 4'h0, d, q);
    endtask : act_w

    task automatic act_r;
        usb_host_model_inst.xfer(TGT_ACTION_BLOCK, 1'b0, ACTION_ADDR, 5'h00, 4'h0, 32'h0, q);
    endtask : act_r

    task automatic cfg_w(input logic [3:0] s, input logic [31:0] d);
        usb_host_model_inst.xfer(TGT_CMD_GEN, 1'b1, 8'h00, SELF_STATION, s, d, q);
    endtask : cfg_w

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    initial begin
        {rstn, logic_input_one, aux_loaded} = 3'b000;
        service_request_in = 24'h800000;
        cyc(8);
        rstn <= 1'b1;
        act_r();
        check("action after reset", q, 32'h0);
        usb_host_model_inst.xfer(TGT_ACTION_BLOCK, 1'b0, 8'h02, 5'h00, 4'h0, 32'h0, q);
        check("action block other addr", q, 32'h0);
        usb_host_model_inst.xfer(TGT_ACTION_BLOCK, 1'b1, 8'h02, 5'h00, 4'h0, 32'h1, q);
        act_r();
        check("action after other addr write", q, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            cfg_w(rows[i].s, rows[i].d);
            usb_host_model_inst.xfer(TGT_CMD_GEN, 1'b0, 8'h00, SELF_STATION, rows[i].s, 32'h0, q);
            check("register file word", q, rows[i].e);
        end
        $display("test register file done");
        for (int t = 0; t < 8; t++) usb_host_model_inst.xfer(3'(t), 1'b0, 8'h00, 5'h01, 4'h0, 32'h0, q);
        for (int k = 0; k < 4; k++) check("target strobe count", 32'(ev[k]), 32'h1);
        $display("test target decode done");
        for (int b = 1; b < 4; b++) act_w(32'h1 << b);
        act_w(32'h0000ffe0);
        cyc(20);
        for (int k = 6; k < 9; k++) check("pulse cycles", 32'(ev[k]), 32'(PULSE_CYCLES));
        act_r();
        check("action after unused bits", q, 32'h0);
        $display("test pulses done");
        act_w(32'h1);
        check("acquire on", {31'h0, acquire}, 32'h1);
        logic_input_one <= 1'b1;
        cyc(3);
        check("start from input one", 32'(ev[4]), 32'h1);
        logic_input_one <= 1'b0;
        service_request_in <= 24'h800001;
        cyc(3);
        check("start from service request", 32'(ev[4]), 32'h2);
        act_w(32'd17);
        check("aux without stack", 32'(ev[5]), 32'h0);
        aux_loaded <= 1'b1;
        act_w(32'd17);
        check("aux start", 32'(ev[5]), 32'h1);
        check("acquire kept", {31'h0, acquire}, 32'h1);
        act_w(32'h0);
        check("acquire off", {31'h0, acquire}, 32'h0);
        act_w(32'h10);
        service_request_in <= 24'h800000;
        logic_input_one <= 1'b1;
        cyc(3);
        check("aux while idle", 32'(ev[5]), 32'h1);
        check("no start while idle", 32'(ev[4]), 32'h2);
        $display("test acquisition done");
        act_w(32'h1);
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        #1;
        check("acquire after reset", {31'h0, acquire}, 32'h0);
        act_r();
        check("action after second reset", q, 32'h0);
        $display("test second reset done");
        cfg_w(SA_DEVICE_SEL, 32'h1);
        cfg_w(SA_GEN_ONE, 32'h00030002);
        cfg_w(SA_OUTPUT_SEL, 32'h2);
        cfg_w(SA_INDICATOR_SEL, 32'h300);
        base = ev;
        act_w(32'h2);
        cyc(24);
        check("gate cycles", 32'(ev[9] - base[9]), 32'h4);
        check("logic output cycles", 32'(ev[10] - base[10]), 32'h4);
        check("green cycles", 32'(ev[11] - base[11]), 32'(PULSE_CYCLES));
        $display("test routing done");
        cfg_w(SA_PERIODIC, 32'h2);
        act_w(32'h1);
        base = ev;
        repeat (2) begin
            logic_input_one <= 1'b0;
            cyc(2);
            logic_input_one <= 1'b1;
            cyc(3);
        end
        check("starts by input one", 32'(ev[4] - base[4]), 32'h2);
        check("aux by event count", 32'(ev[5] - base[5]), 32'h1);
        $display("test periodic done");
        give_verdict();
    end

    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule : crate_controller_register_front_tb
